//--- crdst_pkg.sv
// Constants for the codec reset and default-state block.
// Assumes an APB slave at 10 MHz with 32-bit data and word-aligned registers.
package crdst_pkg;
  localparam int unsigned NCH            = 4;
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned RST_PIN_NS     = 50_000;
  // Least time rounds up
  localparam int unsigned RST_PIN_CYC    = (RST_PIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Register byte addresses
  localparam logic [7:0] GLOBAL_RESET_CONTROL_REG = 8'h00;
  localparam logic [7:0] MCLK_SEL_REG   = 8'h04;
  localparam logic [7:0] STATUS_REG     = 8'h08;
  localparam logic [7:0] CH_BASE        = 8'h10;
  localparam logic [7:0] CH_STRIDE      = 8'h10;
  localparam logic [3:0] CH_CFG_OFS     = 4'h0;
  localparam logic [3:0] CH_FILT_OFS    = 4'h4;
  localparam logic [3:0] CH_IRQ_OFS     = 4'h8;
  localparam logic [3:0] CH_SLOT_OFS    = 4'hc;
  // Reset control fields
  localparam int unsigned HARD_BIT       = 0;
  localparam int unsigned SOFT_BIT       = 1;
  localparam int unsigned MASK_LSB       = 4;
  // Channel config fields: pdown, loop[3:0], cutoff, txsel, rxsel, ioc[3:0], fen[3:0]
  localparam int unsigned CFG_PDOWN      = 0;
  localparam int unsigned CFG_LOOP_LSB   = 1;
  localparam int unsigned CFG_CUT        = 5;
  localparam int unsigned CFG_TXSEL      = 6;
  localparam int unsigned CFG_RXSEL      = 7;
  localparam int unsigned CFG_IOC_LSB    = 8;
  localparam int unsigned CFG_FEN_LSB    = 12;
  localparam logic [15:0] CFG_DEFAULT    = 16'h0001;
  localparam logic [7:0]  FILT_DEFAULT   = 8'h00;
  localparam logic [7:0]  FILT_HPF_MASK  = 8'h01;
  localparam logic [7:0]  IMASK_DEFAULT  = 8'hff;
  localparam logic [1:0]  MCLK_2048      = 2'h0;
  localparam logic [1:0]  MCLK_DEFAULT   = MCLK_2048;
  localparam logic [1:0]  PCM_PIN_FIRST  = 2'h0;
  typedef enum logic [1:0] {CRDST_RUN, CRDST_HOLD} crdst_mode_e;
endpackage

//--- crdst_top.sv
// Reset sequencer and default-state holder for a four-channel codec.
// Assumes an APB master on sys_clk; reset pin and select pins are asynchronous.
`timescale 1ns/1ns
module crdst_top #(
  parameter int unsigned RST_CYC = crdst_pkg::RST_PIN_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_pin_n,
  input  wire logic        parallel_host_interface_mode,
  input  wire logic        slot_select_pin_0,
  input  wire logic        slot_select_pin_1,
  input  wire logic [3:0]  ch_event,
  output logic      [3:0]  ch_power_down,
  output logic      [3:0]  ch_tx_pin_sel,
  output logic      [3:0]  ch_rx_pin_sel,
  output logic      [15:0] io_dir_out,
  output logic      [15:0] func_enable,
  output logic      [7:0]  slot_map,
  output logic             pcm_launch_rising,
  output logic             pcm_sample_rising,
  output logic      [1:0]  mclk_sel,
  output logic             in_reset
);
  localparam int unsigned NCH = crdst_pkg::NCH;

  typedef struct packed {
    logic [2:0]         pin_sync;
    logic [2:0]         sel0_sync;
    logic [2:0]         sel1_sync;
    logic [15:0]        pin_cnt;
    logic               pin_long;
    logic               pin_low;
    logic               hard_req;
    logic [NCH-1:0][15:0] cfg;
    logic [NCH-1:0][7:0]  filt;
    logic [NCH-1:0][7:0]  imask;
    logic [NCH-1:0]       ista;
    logic [1:0]         mclk;
    logic [31:0]        rdata;
    logic               ready;
    logic               err;
    logic [7:0]         slots;
    logic               launch_r;
    logic               sample_r;
  } crdst_state_s;

  crdst_state_s q, d;

  // Stable select level once second and third stage agree
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  logic        acc;
  logic [3:0]  chi;
  logic [3:0]  ofs;
  logic        chv;
  logic        s0;
  logic        s1;
  logic [3:0]  soft_sel;

  always_comb begin
    d        = q;
    acc      = psel && penable && !q.ready;
    chi      = 4'((paddr - crdst_pkg::CH_BASE) >> 4);
    ofs      = paddr[3:0];
    chv      = (paddr >= crdst_pkg::CH_BASE) && (chi < 4'(NCH));
    soft_sel = 4'h0;
    // Three-stage synchronisers
    d.pin_sync  = {q.pin_sync[1:0], reset_pin_n};
    d.sel0_sync = {q.sel0_sync[1:0], slot_select_pin_0};
    d.sel1_sync = {q.sel1_sync[1:0], slot_select_pin_1};
    s0 = agreed(q.sel0_sync, q.slots[0]);
    s1 = agreed(q.sel1_sync, q.slots[1]);
    // Pin low must persist the full minimum before it counts
    if (q.pin_sync[1] == q.pin_sync[2]) begin
      d.pin_low = !q.pin_sync[2];
    end
    if (!q.pin_low) begin
      d.pin_cnt  = 16'h0000;
      d.pin_long = 1'b0;
    end else if (q.pin_cnt >= 16'(RST_CYC - 1)) begin
      d.pin_long = 1'b1;
    end else begin
      d.pin_cnt = q.pin_cnt + 16'h0001;
    end
    // Status events per channel, sticky
    for (int c = 0; c < NCH; c++) begin
      if (ch_event[c]) begin
        d.ista[c] = 1'b1;
      end
    end
    // APB slave, one wait state then ready
    d.ready = acc;
    d.err   = 1'b0;
    d.hard_req = 1'b0;
    if (acc) begin
      d.rdata = 32'h0000_0000;
      if (pwrite) begin
        if (paddr == crdst_pkg::GLOBAL_RESET_CONTROL_REG) begin
          d.hard_req = pwdata[crdst_pkg::HARD_BIT];
          if (pwdata[crdst_pkg::SOFT_BIT]) begin
            soft_sel = pwdata[crdst_pkg::MASK_LSB +: NCH];
          end
        end else if (paddr == crdst_pkg::MCLK_SEL_REG) begin
          d.mclk = pwdata[1:0];
        end else if (chv && ofs == crdst_pkg::CH_CFG_OFS) begin
          d.cfg[chi[1:0]] = pwdata[15:0];
        end else if (chv && ofs == crdst_pkg::CH_FILT_OFS) begin
          d.filt[chi[1:0]] = pwdata[7:0];
        end else if (chv && ofs == crdst_pkg::CH_IRQ_OFS) begin
          d.imask[chi[1:0]] = pwdata[7:0];
        end else if (!(paddr == crdst_pkg::STATUS_REG)) begin
          d.err = 1'b1;
        end
      end else begin
        if (paddr == crdst_pkg::GLOBAL_RESET_CONTROL_REG) begin
          d.rdata = 32'h0000_0000;
        end else if (paddr == crdst_pkg::MCLK_SEL_REG) begin
          d.rdata = {30'h0, q.mclk};
        end else if (paddr == crdst_pkg::STATUS_REG) begin
          d.rdata = {27'h0, q.pin_low, q.ista};
        end else if (chv && ofs == crdst_pkg::CH_CFG_OFS) begin
          d.rdata = {16'h0, q.cfg[chi[1:0]]};
        end else if (chv && ofs == crdst_pkg::CH_FILT_OFS) begin
          d.rdata = {24'h0, q.filt[chi[1:0]]};
        end else if (chv && ofs == crdst_pkg::CH_IRQ_OFS) begin
          d.rdata = {24'h0, q.imask[chi[1:0]]};
        end else if (chv && ofs == crdst_pkg::CH_SLOT_OFS) begin
          d.rdata = {30'h0, q.slots[2*chi[1:0] +: 2]};
        end else begin
          d.err = 1'b1;
        end
      end
    end
    // Per-channel soft reset, other channels untouched
    for (int c = 0; c < NCH; c++) begin
      if (soft_sel[c]) begin
        d.cfg[c]   = crdst_pkg::CFG_DEFAULT;
        d.filt[c]  = crdst_pkg::FILT_DEFAULT | crdst_pkg::FILT_HPF_MASK;
        d.imask[c] = crdst_pkg::IMASK_DEFAULT;
        d.ista[c]  = 1'b0;
      end
    end
    // Slot map: parallel mode fixed, serial-bus mode from select pins
    for (int c = 0; c < NCH; c++) begin
      if (parallel_host_interface_mode) begin
        d.slots[2*c +: 2] = 2'(c);
      end else begin
        d.slots[2*c +: 2] = 2'(c) ^ {s1, s0};
      end
    end
    // Edge use per mode
    d.launch_r = 1'b1;
    d.sample_r = !parallel_host_interface_mode;
    // Global reset: pin, register bit; forces every default
    if (rst || q.pin_long || q.hard_req) begin
      for (int c = 0; c < NCH; c++) begin
        d.cfg[c]   = crdst_pkg::CFG_DEFAULT;
        d.filt[c]  = crdst_pkg::FILT_DEFAULT;
        d.imask[c] = crdst_pkg::IMASK_DEFAULT;
        d.ista[c]  = 1'b0;
      end
      d.mclk = crdst_pkg::MCLK_DEFAULT;
    end
    if (rst) begin
      d.pin_sync  = 3'h7;
      d.sel0_sync = 3'h0;
      d.sel1_sync = 3'h0;
      d.pin_cnt   = 16'h0000;
      d.pin_long  = 1'b0;
      d.pin_low   = 1'b0;
      d.hard_req  = 1'b0;
      d.rdata     = 32'h0000_0000;
      d.ready     = 1'b0;
      d.err       = 1'b0;
      d.slots     = 8'he4;
      d.launch_r  = 1'b1;
      d.sample_r  = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  // Outputs straight from flops
  always_comb begin
    prdata  = q.rdata;
    pready  = q.ready;
    pslverr = q.err;
    for (int c = 0; c < NCH; c++) begin
      ch_power_down[c]      = q.cfg[c][crdst_pkg::CFG_PDOWN];
      ch_tx_pin_sel[c]      = q.cfg[c][crdst_pkg::CFG_TXSEL];
      ch_rx_pin_sel[c]      = q.cfg[c][crdst_pkg::CFG_RXSEL];
      io_dir_out[4*c +: 4]  = q.cfg[c][crdst_pkg::CFG_IOC_LSB +: 4];
      func_enable[4*c +: 4] = q.cfg[c][crdst_pkg::CFG_FEN_LSB +: 4];
    end
    slot_map          = q.slots;
    pcm_launch_rising = q.launch_r;
    pcm_sample_rising = q.sample_r;
    mclk_sel          = q.mclk; // Master clock rate as written to MCLK_SEL_REG
    in_reset          = q.pin_long;
  end

  // Assertions
  pin_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    q.pin_long |=> (q.cfg[0] == crdst_pkg::CFG_DEFAULT && q.imask[3] == crdst_pkg::IMASK_DEFAULT))
    else $error("Pin reset did not restore defaults");
  hard_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    q.hard_req |=> (q.mclk == crdst_pkg::MCLK_DEFAULT && q.filt[2] == crdst_pkg::FILT_DEFAULT))
    else $error("Hard reset bit did not restore defaults");
  soft_hpf_a: assert property (@(posedge sys_clk) disable iff (rst)
    (acc && pwrite && paddr == crdst_pkg::GLOBAL_RESET_CONTROL_REG && pwdata[1] && pwdata[4]
     && !pwdata[0] && !q.pin_long && !q.hard_req) |=> (q.filt[0] == crdst_pkg::FILT_HPF_MASK))
    else $error("Soft reset highpass not set");
  soft_pdown_a: assert property (@(posedge sys_clk) disable iff (rst)
    (acc && pwrite && paddr == crdst_pkg::GLOBAL_RESET_CONTROL_REG && pwdata[1] && pwdata[6])
    |=> ##1 ch_power_down[2])
    else $error("Soft reset channel not powered down");
  soft_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    (acc && pwrite && paddr == crdst_pkg::GLOBAL_RESET_CONTROL_REG && pwdata[1:0] == 2'h2
     && !pwdata[7] && !q.pin_long && !ch_event[3]) |=> $stable(q.ista[3]) && $stable(q.cfg[3]))
    else $error("Unselected channel disturbed");
  par_slot_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(parallel_host_interface_mode) |-> slot_map == 8'he4)
    else $error("Parallel slot map wrong");
  edge_use_a: assert property (@(posedge sys_clk) disable iff (rst)
    pcm_launch_rising && (pcm_sample_rising == !$past(parallel_host_interface_mode)))
    else $error("Edge selection wrong");
  mask_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(q.pin_long) |-> q.imask == {NCH{crdst_pkg::IMASK_DEFAULT}})
    else $error("Masks not set after reset");
  apb_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
    (psel && penable && !pready) |=> pready)
    else $error("APB ready late");
endmodule

//--- crdst_host.sv
// Host model: APB master and reset pin driver for the codec reset block.
// Assumes the bench calls its tasks one at a time on the sys_clk domain.
`timescale 1ns/1ns
module crdst_host (
  input  wire logic        sys_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             reset_pin_n
);
  // Idle bus and released pin at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset_pin_n = 1'b1;
  end
  // One transfer; held until pready, then address and data scrambled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A missing answer shows as unknown so the bench flags it
    if (pready !== 1'b1) begin
      r = 'x;
      e = 1'bx;
    end else begin
      r = prdata;
      e = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // Stale values must not look valid
    pwdata <= ~d;
  endtask
  // Reset pin held low for a given number of cycles
  task automatic pin_low(input int cyc);
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    repeat (cyc) @(posedge sys_clk);
    reset_pin_n <= 1'b1;
  endtask
endmodule

//--- crdst_top_test.sv
// Self-checking bench for the codec reset and default-state block.
// Assumes crdst_pkg, crdst_top and the crdst_host model are compiled first.
`timescale 1ns/1ns
module crdst_top_test;
  localparam int unsigned RC = 8; // Short pin-reset count keeps the run brief
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, reset_pin_n;
  logic        mode, s0, s1, launch, sample, in_reset, le;
  logic [7:0]  paddr, slot_map;
  logic [31:0] pwdata, prdata, lr;
  logic [3:0]  ev, pdn, txs, rxs;
  logic [15:0] iod, fen;
  logic [1:0]  mclk;
  int          fails, n_tests;
  crdst_top #(.RST_CYC(RC)) uut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
    .parallel_host_interface_mode(mode), .slot_select_pin_0(s0), .slot_select_pin_1(s1),
    .ch_event(ev), .ch_power_down(pdn), .ch_tx_pin_sel(txs), .ch_rx_pin_sel(rxs),
    .io_dir_out(iod), .func_enable(fen), .slot_map(slot_map), .pcm_launch_rising(launch),
    .pcm_sample_rising(sample), .mclk_sel(mclk), .in_reset(in_reset));
  crdst_host host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n));
  function automatic logic [7:0] ca(int n, logic [3:0] o);
    return crdst_pkg::CH_BASE + 8'(n) * crdst_pkg::CH_STRIDE + {4'h0, o};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, lr, le);
    chk("write err", {31'h0, le}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    host.xfer(1'b0, a, 32'h0, lr, le);
    chk(nm, lr, exp);
  endtask
  // Every channel moved away from its defaults, master clock too
  task automatic cfg_all();
    for (int n = 0; n < 4; n++) begin
      wr(ca(n, crdst_pkg::CH_CFG_OFS), 32'h0000_fffe);
      wr(ca(n, crdst_pkg::CH_FILT_OFS), 32'h0000_0002);
      wr(ca(n, crdst_pkg::CH_IRQ_OFS), 32'h0);
    end
    wr(crdst_pkg::MCLK_SEL_REG, 32'h1);
  endtask
  // Full default state at the ports, the master clock register and each channel's cfg, filter and mask registers
  task automatic defaults(input logic [7:0] sm, input logic smp);
    chk("power down", pdn, 4'hf);
    chk("tx sel", txs, 4'h0);
    chk("rx sel", rxs, 4'h0);
    chk("io dir", iod, 16'h0);
    chk("func en", fen, 16'h0);
    chk("mclk", mclk, crdst_pkg::MCLK_2048);
    chk("slot map", slot_map, sm);
    chk("launch", launch, 1'b1);
    chk("sample", sample, smp);
    rd(crdst_pkg::MCLK_SEL_REG, 32'h0, "mclk reg");
    for (int n = 0; n < 4; n++) begin
      rd(ca(n, crdst_pkg::CH_CFG_OFS), {16'h0, crdst_pkg::CFG_DEFAULT}, "cfg");
      rd(ca(n, crdst_pkg::CH_FILT_OFS), {24'h0, crdst_pkg::FILT_DEFAULT}, "filt");
      rd(ca(n, crdst_pkg::CH_IRQ_OFS), {24'h0, crdst_pkg::IMASK_DEFAULT}, "mask");
    end
  endtask
  task automatic t_defaults();
    defaults(8'he4, 1'b0);
    rd(8'h0c, 32'h0, "unmapped read");
    chk("unmapped err", {31'h0, le}, 32'h1);
    rd(crdst_pkg::GLOBAL_RESET_CONTROL_REG, 32'h0, "ctrl read");
    $display("test defaults done");
  endtask
  // Channels 1 and 3 reset, 2 and 4 keep their settings and status
  task automatic t_soft();
    cfg_all();
    @(posedge sys_clk);
    ev <= 4'hf;
    @(posedge sys_clk);
    ev <= 4'h0;
    wr(crdst_pkg::GLOBAL_RESET_CONTROL_REG, 32'h0000_0052);
    chk("soft pdown", pdn, 4'b0101);
    chk("soft tx", txs, 4'b1010);
    chk("soft rx", rxs, 4'b1010);
    chk("soft io", iod, 16'hf0f0);
    chk("soft func", fen, 16'hf0f0);
    chk("soft slots", slot_map, 8'he4);
    rd(crdst_pkg::STATUS_REG, 32'h0000_000a, "soft status");
    for (int n = 0; n < 4; n++) begin
      rd(ca(n, crdst_pkg::CH_CFG_OFS), n[0] ? 32'hfffe : 32'h0001, "soft cfg");
      rd(ca(n, crdst_pkg::CH_FILT_OFS), n[0] ? 32'h02 : 32'h01, "soft filt");
      rd(ca(n, crdst_pkg::CH_IRQ_OFS), n[0] ? 32'h00 : 32'hff, "soft mask");
    end
    rd(crdst_pkg::MCLK_SEL_REG, 32'h1, "soft mclk");
    $display("test soft reset done");
  endtask
  task automatic t_hard();
    cfg_all();
    wr(crdst_pkg::GLOBAL_RESET_CONTROL_REG, 32'h1);
    repeat (3) @(posedge sys_clk);
    defaults(8'he4, 1'b0);
    $display("test hard bit done");
  endtask
  // Too short a pulse is ignored, a long one restores defaults
  task automatic t_pin();
    cfg_all();
    host.pin_low(RC / 2);
    repeat (8) @(posedge sys_clk);
    chk("short pulse", pdn, 4'h0);
    fork
      host.pin_low(RC + 12);
      begin
        repeat (RC + 10) @(posedge sys_clk);
        chk("in reset", in_reset, 1'b1);
      end
    join
    repeat (3) @(posedge sys_clk);
    defaults(8'he4, 1'b0);
    $display("test pin reset done");
  endtask
  // Serial-bus mode: slot of channel n is n xor select pins
  task automatic t_gci();
    mode <= 1'b0;
    s1 <= 1'b1;
    s0 <= 1'b0;
    wr(crdst_pkg::GLOBAL_RESET_CONTROL_REG, 32'h1);
    repeat (6) @(posedge sys_clk);
    chk("gci slots", slot_map, 8'h4e);
    chk("gci sample", sample, 1'b1);
    chk("gci launch", launch, 1'b1);
    mode <= 1'b1;
    s1 <= 1'b0;
    wr(crdst_pkg::GLOBAL_RESET_CONTROL_REG, 32'h1);
    repeat (6) @(posedge sys_clk);
    chk("mpi slots", slot_map, 8'he4);
    $display("test serial mode done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    mode = 1'b1;
    s0 = 1'b0;
    s1 = 1'b0;
    ev = 4'h0;
    fails = 0;
    n_tests = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_defaults();
    t_soft();
    t_hard();
    t_pin();
    t_gci();
    stop_test();
  end
endmodule
